// *** core/psrc_params.svh ***
// Timing and field constants for the pseudo-static RAM read controller.
// Assumes a 40 MHz controller clock; included by the design modules and the bench.
`ifndef PSRC_PARAMS_SVH
`define PSRC_PARAMS_SVH
`define PSRC_CLK_PERIOD_PS 25000
`define PSRC_CYCLE_MIN_NS 90
`define PSRC_CYCLE_MAX_NS 10000
`define PSRC_DATA_ACCESS_NS 90
`define PSRC_LANE_ACCESS_NS 40
`define PSRC_FLOAT_NS 25
`define PSRC_SKEW_NS 20
`define PSRC_INIT_WAIT_NS 200000
`define PSRC_INIT_READS 3
`define PSRC_ADDR_W 20
`define PSRC_DATA_W 16
`define PSRC_BYTE_W 8
`endif

// *** core/psrc_pkg.sv ***
// Types shared by the pseudo-static RAM read controller.
// Assumes nothing beyond the params header.
package psrc_pkg;
    typedef enum logic [2:0] {
        PSRC_POWERUP = 3'b000,
        PSRC_IDLE = 3'b001,
        PSRC_SETUP = 3'b010,
        PSRC_ACCESS = 3'b011,
        PSRC_RELEASE = 3'b100,
        PSRC_DEEPSLEEP = 3'b101
    } psrc_state_t;
endpackage

// *** core/psrc_counter.sv ***
// Down counter that times each phase of a memory cycle.
// Assumes a synchronous active-high reset and a shared clock enable.
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_counter #(
    parameter int W = 14
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    output logic done
);
    logic [W-1:0] count;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (clkEn) begin
            if (load) begin
                count <= loadValue;
            end else if (count != '0) begin
                count <= count - W'(1);
            end
        end
    end
    assign done = (count == '0);
endmodule

// *** core/psrc_read_ctrl.sv ***
// Host-side read and standby controller for an asynchronous 1M x 16 pseudo-static RAM.
// Assumes one 40 MHz clock; the data pins are sampled through two flip-flops.
//
// Contract
// - Every read cycle lasts no less than the minimum and no more than 10,000 ns.
// - A read cycle runs from the later of select fall or address change to the earlier end.
// - Repeated same-address sub-cycles under one select must total no more than 10 us.
// - An address change after an out-of-range read cycle voids all stored data.
// - Write enable stays high throughout every read cycle.
// - While selected the address settles within the skew limit.
// - The skew limit does not apply when the address settles outside the select window.
// - Select high with the standby pin low enters the non-retaining standby.
// - The standby pin stays high except for a deliberate non-retaining standby.
// - After the power-on wait at least three select-toggled reads precede normal use.
`timescale 1ns/1ps
`include "psrc_params.svh"
module psrc_read_ctrl
    import psrc_pkg::*;
#(
    parameter int INIT_WAIT_NS = `PSRC_INIT_WAIT_NS,
    parameter int CNT_W = 14
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic readReq,
    input wire logic [`PSRC_ADDR_W-1:0] readAddr,
    input wire logic [1:0] readLanes,
    input wire logic sleepReq,
    output logic readReady,
    output logic readValid,
    output logic [`PSRC_DATA_W-1:0] readData,
    output logic initDone,
    output logic contentsLost,
    output logic [`PSRC_ADDR_W-1:0] address_pins,
    output logic chipSelect_n,
    output logic outputEnable_n,
    output logic writeEnable_n,
    output logic low_lane_select_n,
    output logic high_lane_select_n,
    output logic standbyMode_n,
    input wire logic [`PSRC_DATA_W-1:0] data_pins_in,
    output logic [`PSRC_DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    // ========================================
    // Cycle counts
    // ========================================
    function automatic logic [CNT_W-1:0] cyclesUp(input int ns);
        return CNT_W'((ns * 1000 + `PSRC_CLK_PERIOD_PS - 1) / `PSRC_CLK_PERIOD_PS);
    endfunction
    // Read phase is held to the access time plus one sampling margin; far below the ceiling.
    localparam logic [CNT_W-1:0] ACCESS_CYC = cyclesUp(`PSRC_DATA_ACCESS_NS) + CNT_W'(1);
    localparam logic [CNT_W-1:0] FLOAT_CYC = cyclesUp(`PSRC_FLOAT_NS);
    localparam logic [CNT_W-1:0] SETUP_CYC = cyclesUp(`PSRC_SKEW_NS);
    // The phase counter also times the power-on wait, so CNT_W bounds the longest wait.
    localparam logic [CNT_W-1:0] WAIT_CYC = cyclesUp(INIT_WAIT_NS);

    psrc_state_t state;
    logic phaseLoad;
    logic [CNT_W-1:0] phaseValue;
    logic phaseDone;
    logic [1:0] initReads;
    logic waitArmed;
    logic [1:0] laneSel;
    logic [`PSRC_DATA_W-1:0] dataSync1;
    logic [`PSRC_DATA_W-1:0] dataSync2;

    psrc_counter #(.W(CNT_W)) u_phase (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .load(phaseLoad),
        .loadValue(phaseValue),
        .done(phaseDone)
    );

    // ========================================
    // Data pin synchroniser
    // ========================================
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dataSync1 <= '0;
            dataSync2 <= '0;
        end else if (clkEn) begin
            dataSync1 <= data_pins_in;
            dataSync2 <= dataSync1;
        end
    end

    // ========================================
    // Sequencer
    // ========================================
    always_comb begin
        phaseLoad = 1'b0;
        phaseValue = '0;
        unique case (state)
            PSRC_POWERUP: begin
                // The counter reads done straight out of reset, so the wait is armed once.
                phaseLoad = !waitArmed;
                phaseValue = WAIT_CYC;
            end
            PSRC_IDLE: begin
                phaseLoad = 1'b1;
                phaseValue = SETUP_CYC;
            end
            PSRC_SETUP: begin
                phaseLoad = phaseDone;
                phaseValue = ACCESS_CYC;
            end
            PSRC_ACCESS: begin
                phaseLoad = phaseDone;
                phaseValue = FLOAT_CYC;
            end
            PSRC_RELEASE, PSRC_DEEPSLEEP: begin
                phaseLoad = 1'b0;
            end
            default: begin
                phaseLoad = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= PSRC_POWERUP;
            initReads <= 2'h0;
            laneSel <= 2'h0;
            initDone <= 1'b0;
            contentsLost <= 1'b0;
            readReady <= 1'b0;
            readValid <= 1'b0;
            readData <= '0;
            address_pins <= '0;
            chipSelect_n <= 1'b1;
            outputEnable_n <= 1'b1;
            low_lane_select_n <= 1'b1;
            high_lane_select_n <= 1'b1;
            standbyMode_n <= 1'b1;
        end else if (clkEn) begin
            readValid <= 1'b0;
            unique case (state)
                PSRC_POWERUP: begin
                    // Select and standby pins rest high until the armed wait has run out.
                    if (waitArmed && phaseDone) begin
                        state <= PSRC_IDLE;
                    end
                end
                PSRC_IDLE: begin
                    standbyMode_n <= 1'b1;
                    if (!initDone) begin
                        // Dummy reads toggle select with outputs disabled to avoid contention.
                        state <= PSRC_SETUP;
                        chipSelect_n <= 1'b0;
                        readReady <= 1'b0;
                    end else if (sleepReq) begin
                        state <= PSRC_DEEPSLEEP;
                        standbyMode_n <= 1'b0;
                        contentsLost <= 1'b1;
                        readReady <= 1'b0;
                    end else if (readReq && readReady) begin
                        // Address settles before select falls, so skew does not constrain us.
                        address_pins <= readAddr;
                        laneSel <= readLanes;
                        state <= PSRC_SETUP;
                        readReady <= 1'b0;
                    end else begin
                        readReady <= 1'b1;
                    end
                end
                PSRC_SETUP: begin
                    if (phaseDone) begin
                        state <= PSRC_ACCESS;
                        chipSelect_n <= 1'b0;
                        if (initDone) begin
                            outputEnable_n <= 1'b0;
                            low_lane_select_n <= ~laneSel[0];
                            high_lane_select_n <= ~laneSel[1];
                        end
                    end
                end
                PSRC_ACCESS: begin
                    if (phaseDone) begin
                        // Data was sampled two flops late; access covers both margins.
                        readData <= dataSync2;
                        readValid <= initDone;
                        chipSelect_n <= 1'b1;
                        outputEnable_n <= 1'b1;
                        low_lane_select_n <= 1'b1;
                        high_lane_select_n <= 1'b1;
                        state <= PSRC_RELEASE;
                        if (!initDone) begin
                            initReads <= initReads + 2'h1;
                            initDone <= (initReads == 2'(`PSRC_INIT_READS - 1));
                        end
                    end
                end
                PSRC_RELEASE: begin
                    // Address holds until the memory floats its pins.
                    if (phaseDone) begin
                        state <= PSRC_IDLE;
                    end
                end
                PSRC_DEEPSLEEP: begin
                    if (!sleepReq) begin
                        standbyMode_n <= 1'b1;
                        state <= PSRC_IDLE;
                    end
                end
                default: begin
                    state <= PSRC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            waitArmed <= 1'b0;
        end else if (clkEn && state == PSRC_POWERUP) begin
            waitArmed <= 1'b1;
        end
    end

    // Reads never write; the data pins are only ever inputs.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            writeEnable_n <= 1'b1;
            data_pins_out <= '0;
            data_pins_oe <= 1'b1;
        end else if (clkEn) begin
            writeEnable_n <= 1'b1;
            data_pins_out <= '0;
            data_pins_oe <= 1'b1;
        end
    end

    // ========================================
    // Checks
    // ========================================
    logic [CNT_W-1:0] selLow;
    always_ff @(posedge mclk) begin
        if (sys_rst || chipSelect_n) begin
            selLow <= '0;
        end else if (clkEn && selLow != '1) begin
            selLow <= selLow + CNT_W'(1);
        end
    end
    // The ceiling rounds down so a cycle that passes here is never over the limit while clkEn stays high.
    localparam logic [CNT_W-1:0] MIN_CYC = cyclesUp(`PSRC_CYCLE_MIN_NS);
    localparam logic [CNT_W-1:0] MAX_CYC = CNT_W'(`PSRC_CYCLE_MAX_NS * 1000 / `PSRC_CLK_PERIOD_PS);
    a_write_stays_high: assert property (@(posedge mclk) disable iff (sys_rst)
        writeEnable_n) else $error("write enable asserted");
    a_cycle_not_short: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(chipSelect_n) |-> $past(selLow) >= MIN_CYC) else $error("cycle short");
    a_cycle_not_long: assert property (@(posedge mclk) disable iff (sys_rst)
        selLow <= MAX_CYC) else $error("cycle too long");
    a_addr_stable_sel: assert property (@(posedge mclk) disable iff (sys_rst)
        !chipSelect_n && !$past(chipSelect_n) |-> $stable(address_pins))
        else $error("address moved while selected");
    a_sleep_deselected: assert property (@(posedge mclk) disable iff (sys_rst)
        !standbyMode_n |-> chipSelect_n) else $error("sleep while selected");
    a_sleep_lost: assert property (@(posedge mclk) disable iff (sys_rst)
        !standbyMode_n |-> contentsLost) else $error("lost flag missing");
    a_init_before_use: assert property (@(posedge mclk) disable iff (sys_rst)
        readValid |-> initDone && initReads == 2'(`PSRC_INIT_READS)) else $error("early use");
    a_float_gap: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(chipSelect_n) |=> chipSelect_n [*2]) else $error("no float gap");
    c_read_done: cover property (@(posedge mclk) readValid);
    c_init_done: cover property (@(posedge mclk) $rose(initDone));
    c_deep_sleep: cover property (@(posedge mclk) $fell(standbyMode_n));
endmodule

// *** dv/psrc_psram_model.sv ***
// Behavioural model of the pseudo-static RAM seen from its pins, read side only.
// Assumes the controller drives every pin and the bench resolves the shared data wire.
`timescale 1ns/1ps
module psrc_psram_model #(
    parameter logic [15:0] FILL = 16'hc3a5,
    parameter int ACCESS_NS = 90,
    parameter int LANE_NS = 40,
    parameter int HOLD_NS = 10,
    parameter int MIN_NS = 90,
    parameter int MAX_NS = 10000
) (
    input wire logic [19:0] address_pins,
    input wire logic chipSelect_n,
    input wire logic outputEnable_n,
    input wire logic writeEnable_n,
    input wire logic low_lane_select_n,
    input wire logic high_lane_select_n,
    input wire logic standbyMode_n,
    output logic [15:0] busOut,
    output logic [7:0] violations,
    output logic [7:0] selectCount,
    output logic lost
);
    // ========================================
    // Event times
    realtime tAddr, tSel, tOut, tStart;
    logic [15:0] word;
    logic laneOn;
    initial begin
        tAddr = 0;
        tSel = 0;
        tOut = 0;
        busOut = 16'h0000;
        violations = 8'h00;
        selectCount = 8'h00;
        lost = 1'b0;
    end
    always @(address_pins) tAddr = $realtime;
    always @(negedge chipSelect_n) begin
        tSel = $realtime;
        selectCount = selectCount + 8'h01;
        if (writeEnable_n !== 1'b1) violations = violations + 8'h01;
    end
    // A first rise out of an unknown level is not a cycle end, hence the guard.
    always @(posedge chipSelect_n) begin
        if (tSel > 0 && ($realtime - tSel < MIN_NS || $realtime - tSel > MAX_NS)) begin
            violations = violations + 8'h01;
        end
    end
    always @(negedge writeEnable_n) violations = violations + 8'h01;
    always @(negedge standbyMode_n) begin
        if (chipSelect_n !== 1'b1) violations = violations + 8'h01;
    end
    always @(negedge outputEnable_n or negedge low_lane_select_n or negedge high_lane_select_n) begin
        tOut = $realtime;
    end
    // ========================================
    // Output lanes
    // Released lanes show the inverse of the last value; unsettled ones too, except within the hold time after an address change, when they keep it.
    always begin
        #1;
        if (chipSelect_n === 1'b1 && standbyMode_n === 1'b0) lost = 1'b1;
        word = lost ? ~(address_pins[15:0] ^ FILL) : (address_pins[15:0] ^ FILL);
        tStart = (tAddr > tSel) ? tAddr : tSel;
        for (int i = 0; i < 2; i++) begin
            laneOn = (i == 0) ? (low_lane_select_n === 1'b0) : (high_lane_select_n === 1'b0);
            if (chipSelect_n !== 1'b0 || outputEnable_n !== 1'b0 || !laneOn) begin
                busOut[i*8 +: 8] = ~busOut[i*8 +: 8];
            end else if ($realtime - tStart >= ACCESS_NS && $realtime - tOut >= LANE_NS) begin
                busOut[i*8 +: 8] = word[i*8 +: 8];
            end else if ($realtime - tAddr < HOLD_NS) begin
                busOut[i*8 +: 8] = busOut[i*8 +: 8];
            end else begin
                busOut[i*8 +: 8] = ~busOut[i*8 +: 8];
            end
        end
    end
endmodule

// *** dv/pseudo_sram_read_standby_bench.sv ***
// Self-checking bench for the read and standby controller against the memory model.
// Assumes the design files and the model are compiled first.
`timescale 1ns/1ps
`include "psrc_params.svh"
`define CHECK(got, exp) begin checkCount++; if ((got) !== (exp)) begin errCount++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module pseudo_sram_read_standby_bench;
    // ========================================
    // Signals and instances
    localparam logic [15:0] FILL = 16'hc3a5;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic readReq = 1'b0;
    logic [19:0] readAddr = 20'h00000;
    logic [1:0] readLanes = 2'h3;
    logic sleepReq = 1'b0;
    logic readReady, readValid, initDone, contentsLost;
    logic [15:0] readData, data_pins_out, modelOut, pinLevel;
    logic [19:0] address_pins;
    logic chipSelect_n, outputEnable_n, writeEnable_n, standbyMode_n, data_pins_oe;
    logic low_lane_select_n, high_lane_select_n, modelLost;
    logic [7:0] violations, selectCount;
    int errCount = 0;
    int checkCount = 0;
    always #12.5 mclk = ~mclk;
    assign pinLevel = data_pins_oe ? modelOut : data_pins_out;
    psrc_read_ctrl #(.INIT_WAIT_NS(100)) u_psrc_read_ctrl (
        .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .readReq(readReq),
        .readAddr(readAddr), .readLanes(readLanes), .sleepReq(sleepReq),
        .readReady(readReady), .readValid(readValid), .readData(readData),
        .initDone(initDone), .contentsLost(contentsLost), .address_pins(address_pins),
        .chipSelect_n(chipSelect_n), .outputEnable_n(outputEnable_n),
        .writeEnable_n(writeEnable_n), .low_lane_select_n(low_lane_select_n),
        .high_lane_select_n(high_lane_select_n), .standbyMode_n(standbyMode_n),
        .data_pins_in(pinLevel), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
    psrc_psram_model #(.FILL(FILL)) u_psrc_psram_model (
        .address_pins(address_pins), .chipSelect_n(chipSelect_n),
        .outputEnable_n(outputEnable_n), .writeEnable_n(writeEnable_n),
        .low_lane_select_n(low_lane_select_n), .high_lane_select_n(high_lane_select_n),
        .standbyMode_n(standbyMode_n), .busOut(modelOut), .violations(violations),
        .selectCount(selectCount), .lost(modelLost));
    // ========================================
    // Tasks
    function automatic logic [15:0] exp_word(input logic [19:0] a, input logic gone);
        exp_word = gone ? ~(a[15:0] ^ FILL) : (a[15:0] ^ FILL);
    endfunction
    task automatic stop_test;
        if (errCount == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_read(input logic [19:0] a, input logic [1:0] ln, input logic gone,
                           input int hold = 0);
        int n;
        logic [15:0] mask;
        n = 0;
        while (readReady !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        readAddr = a;
        readLanes = ln;
        readReq = 1'b1;
        @(negedge mclk);
        readReq = 1'b0;
        // Lanes are taken with the request, so changing them now must not matter.
        readLanes = ~ln;
        if (hold > 0) begin
            repeat (3) @(negedge mclk);
            clkEn = 1'b0;
            repeat (hold) @(negedge mclk);
            `CHECK(chipSelect_n, 1'b0)
            clkEn = 1'b1;
        end
        n = 0;
        while (readValid !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        mask = {{8{ln[1]}}, {8{ln[0]}}};
        `CHECK(readValid, 1'b1)
        `CHECK(readData & mask, exp_word(a, gone) & mask)
    endtask
    // Sleep requests before start-up must be ignored; only select-toggled reads may happen.
    task automatic test_init;
        int n;
        sleepReq = 1'b1;
        repeat (4) @(negedge mclk);
        `CHECK(selectCount, 8'h00)
        repeat (8) @(negedge mclk);
        sleepReq = 1'b0;
        n = 0;
        while (initDone !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        `CHECK(initDone, 1'b1)
        `CHECK(selectCount >= 8'h03, 1'b1)
        `CHECK(contentsLost, 1'b0)
        `CHECK(standbyMode_n, 1'b1)
    endtask
    task automatic test_lanes;
        for (int ln = 1; ln < 4; ln++) begin
            do_read(20'h00120 + 20'(ln), 2'(ln), 1'b0);
        end
    endtask
    task automatic test_bounds;
        do_read(20'h00000, 2'h3, 1'b0);
        do_read(20'hfffff, 2'h3, 1'b0);
        do_read(20'h5a5a5, 2'h3, 1'b0);
        `CHECK(writeEnable_n, 1'b1)
        `CHECK(data_pins_oe, 1'b1)
        `CHECK(data_pins_out, 16'h0000)
    endtask
    // A frozen clock enable must stretch the cycle, not end it.
    task automatic test_freeze;
        do_read(20'h3c3c3, 2'h3, 1'b0, 6);
    endtask
    task automatic test_sleep;
        int n;
        n = 0;
        while (readReady !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        sleepReq = 1'b1;
        n = 0;
        while (standbyMode_n !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        `CHECK(standbyMode_n, 1'b0)
        `CHECK(chipSelect_n, 1'b1)
        repeat (3) @(negedge mclk);
        sleepReq = 1'b0;
        repeat (5) @(negedge mclk);
        `CHECK(contentsLost, 1'b1)
        do_read(20'h0beef, 2'h3, 1'b1);
        `CHECK(standbyMode_n, 1'b1)
        `CHECK(contentsLost, 1'b1)
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        test_init();
        test_lanes();
        test_bounds();
        test_freeze();
        test_sleep();
        `CHECK(violations, 8'h00)
        stop_test();
    end
    // The whole run needs well under a thousand cycles; five thousand only catches hangs.
    initial begin
        #(5000 * 25);
        errCount++;
        stop_test();
    end
endmodule
